// ==== core/debug_cmd_map.svh ====
// constants of the debug command decoder: fields, opcodes, responses, register offsets
`ifndef DEBUG_CMD_MAP_SVH
`define DEBUG_CMD_MAP_SVH

// serial frame
`define FRAME_BITS      17
`define FRAME_LAST_BIT  5'h10
`define SC_BIT          16

// operation word fields
`define OPC_MSB         15
`define OPC_LSB         10
`define DIR_BIT         8
`define SIZE_MSB        7
`define SIZE_LSB        6
`define AD_BIT          3
`define REGN_MSB        2
`define REGN_LSB        0

// opcodes
`define OP_NULL         6'h00
`define OP_RD_CORE      6'h01
`define OP_WR_CORE      6'h02
`define OP_MEM_RD       6'h03
`define OP_MEM_WR       6'h04
`define OP_BLK_RD       6'h05
`define OP_BLK_FILL     6'h06
`define OP_RESUME       6'h07
`define OP_RD_CTRL      6'h08
`define OP_WR_CTRL      6'h09
`define OP_RD_DBG       6'h0a
`define OP_WR_DBG       6'h0b

// device responses
`define RESP_COMPLETE   17'h0ffff
`define RESP_NOT_READY  17'h10000
`define RESP_BUS_ERR    17'h10001
`define RESP_ILLEGAL    17'h1ffff

// software registers, byte offsets
`define REG_CTRL        5'h00
`define REG_STATUS      5'h04
`define REG_LAST_RESP   5'h08
`define REG_BLOCK_ADDR  5'h0c
`define REG_CMD_COUNT   5'h10
`define CTRL_RESET      1'h1

`endif

// ==== core/debug_cmd_pkg.sv ====
// types shared by the debug command decoder
package debug_cmd_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10,
        SZ_RSVD = 2'b11
    } op_size_t;

    typedef enum logic [2:0] {
        TGT_NONE      = 3'b000,
        TGT_CORE_REG  = 3'b001,
        TGT_CTRL_REG  = 3'b010,
        TGT_DEBUG_REG = 3'b011,
        TGT_MEMORY    = 3'b100
    } acc_target_t;

    typedef enum logic [1:0] {
        ST_RESULT = 2'b00,
        ST_EXT    = 2'b01,
        ST_EXEC   = 2'b10
    } dec_state_t;
endpackage

// ==== core/debug_command_decoder.sv ====
// debug command decoder: decodes serial debug commands and runs the resulting accesses
// How it works
// - opcode word first, extension words follow
// - opcode in bits fifteen to ten
// - direction bit set means device to host
// - size field selects byte, word, long
// - addresses are always full 32-bit values
// - class bit picks address or data register
// - register number from lowest three bits
// - core register read needs halted core
// - core register write needs halted core
// - memory read uses stolen bus cycle
// - memory write uses stolen bus cycle
// - block read follows memory read, address advances
// - block fill follows memory write, address advances
// - resume while halted restarts execution
// - null command does nothing, reports complete
// - control register read needs halted core
// - control register write needs halted core
// - debug register read runs alongside core
// - debug register write needs halted core
// - frames are 17 bits, status bit first
// - fixed encodings for complete, busy, errors
// - unknown opcode acts null, answers illegal
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "debug_cmd_map.svh"

module debug_command_decoder (
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    input  wire logic [4:0]                 address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [31:0]                writedata,
    output logic      [31:0]                readdata,
    output logic                            waitrequest,
    input  wire logic                       debugSerialClock,
    input  wire logic                       debugSerialIn,
    output logic                            debugSerialOut,
    input  wire logic                       coreHalted,
    output logic                            accReq,
    output debug_cmd_pkg::acc_target_t      accTarget,
    output logic                            accWrite,
    output debug_cmd_pkg::op_size_t         accSize,
    output logic      [31:0]                accAddr,
    output logic      [31:0]                accWdata,
    output logic                            accRegClass,
    output logic      [2:0]                 accRegNum,
    input  wire logic                       accAck,
    input  wire logic                       accErr,
    input  wire logic [31:0]                accRdata,
    output logic                            resumeReq
);
    import debug_cmd_pkg::*;

    logic        wordDone;
    logic [16:0] rxWord;
    logic [16:0] txWord;
    logic        linkEnable_reg;
    dec_state_t  state_reg;
    logic [1:0]  resLeft_reg;
    logic [16:0] resHi_reg;
    logic [16:0] resLo_reg;
    logic [15:0] opWord_reg;
    acc_target_t tgt_reg;
    logic        needHalt_reg;
    logic        hasAddr_reg;
    logic [2:0]  extLeft_reg;
    logic [2:0]  extIdx_reg;
    logic [31:0] addr_reg;
    logic [31:0] data_reg;
    logic [31:0] accAddr_reg;
    logic        accReq_reg;
    logic        resumeReq_reg;
    logic        rdChain_reg;
    logic        wrChain_reg;
    logic        busAck_reg;
    logic [31:0] readdata_reg;
    logic [16:0] lastResp_reg;
    logic [15:0] cmdCount_reg;

    // decode of the word just received
    logic [5:0]  decOpc;
    op_size_t    decSize;
    logic [2:0]  decDataWords;
    logic        decKnown;
    logic        decSized;
    logic        decHalt;
    logic        decAddr;
    logic [2:0]  decExt;
    acc_target_t decTgt;
    logic        decIllegal;
    logic        opcodeSlot;
    op_size_t    curSize;
    logic [31:0] alignedAddr;
    logic [31:0] addrStep;

    debug_serial_shifter shifter (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .enable    (linkEnable_reg),
        .serialClk (debugSerialClock),
        .serialIn  (debugSerialIn),
        .txWord    (txWord),
        .serialOut (debugSerialOut),
        .wordDone  (wordDone),
        .rxWord    (rxWord)
    );

    // the transfer that returns the last result word carries the next opcode
    assign opcodeSlot = wordDone && (state_reg == ST_RESULT) && (resLeft_reg == 2'd1);

    always_comb begin
        decOpc = rxWord[`OPC_MSB:`OPC_LSB];
        decSize = op_size_t'(rxWord[`SIZE_MSB:`SIZE_LSB]);
        decDataWords = (decSize == SZ_LONG) ? 3'd2 : 3'd1;
        decKnown = 1'b1;
        decSized = 1'b0;
        decHalt = 1'b0;
        decAddr = 1'b0;
        decExt = 3'd0;
        decTgt = TGT_NONE;
        case (decOpc)
            `OP_NULL: begin
                decTgt = TGT_NONE;
            end
            `OP_RD_CORE: begin
                decHalt = 1'b1;
                decTgt = TGT_CORE_REG;
            end
            `OP_WR_CORE: begin
                decHalt = 1'b1;
                decTgt = TGT_CORE_REG;
                decExt = 3'd2;
            end
            `OP_MEM_RD: begin
                decSized = 1'b1;
                decAddr = 1'b1;
                decTgt = TGT_MEMORY;
                decExt = 3'd2;
            end
            `OP_MEM_WR: begin
                decSized = 1'b1;
                decAddr = 1'b1;
                decTgt = TGT_MEMORY;
                decExt = 3'd2 + decDataWords;
            end
            `OP_BLK_RD: begin
                decSized = 1'b1;
                decTgt = TGT_MEMORY;
            end
            `OP_BLK_FILL: begin
                decSized = 1'b1;
                decTgt = TGT_MEMORY;
                decExt = decDataWords;
            end
            `OP_RESUME: begin
                decHalt = 1'b1;
            end
            `OP_RD_CTRL: begin
                decHalt = 1'b1;
                decAddr = 1'b1;
                decTgt = TGT_CTRL_REG;
                decExt = 3'd2;
            end
            `OP_WR_CTRL: begin
                decHalt = 1'b1;
                decAddr = 1'b1;
                decTgt = TGT_CTRL_REG;
                decExt = 3'd4;
            end
            `OP_RD_DBG: begin
                decTgt = TGT_DEBUG_REG;
            end
            `OP_WR_DBG: begin
                decHalt = 1'b1;
                decTgt = TGT_DEBUG_REG;
                decExt = 3'd2;
            end
            default: begin
                decKnown = 1'b0;
            end
        endcase
        // block commands are only valid after an error-free memory access of the same direction; null and illegal commands in between do not break this
        decIllegal = !decKnown || (decSized && decSize == SZ_RSVD)
                     || (decOpc == `OP_BLK_RD && !rdChain_reg)
                     || (decOpc == `OP_BLK_FILL && !wrChain_reg);
    end

    assign curSize = op_size_t'(opWord_reg[`SIZE_MSB:`SIZE_LSB]);
    assign alignedAddr = (curSize == SZ_LONG) ? {addr_reg[31:2], 2'b00} :
                         (curSize == SZ_WORD) ? {addr_reg[31:1], 1'b0} : addr_reg;
    assign addrStep = (curSize == SZ_LONG) ? 32'h00000004 :
                      (curSize == SZ_WORD) ? 32'h00000002 : 32'h00000001;

    // every transfer outside the result phase answers not ready
    assign txWord = (state_reg != ST_RESULT) ? `RESP_NOT_READY :
                    (resLeft_reg == 2'd2) ? resHi_reg : resLo_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_RESULT;
            resLeft_reg <= 2'd1;
            resHi_reg <= `RESP_COMPLETE;
            resLo_reg <= `RESP_COMPLETE;
            opWord_reg <= 16'h0000;
            tgt_reg <= TGT_NONE;
            needHalt_reg <= 1'b0;
            hasAddr_reg <= 1'b0;
            extLeft_reg <= 3'd0;
            extIdx_reg <= 3'd0;
            addr_reg <= 32'h00000000;
            data_reg <= 32'h00000000;
            accAddr_reg <= 32'h00000000;
            accReq_reg <= 1'b0;
            resumeReq_reg <= 1'b0;
            rdChain_reg <= 1'b0;
            wrChain_reg <= 1'b0;
        end else begin
            resumeReq_reg <= 1'b0;
            case (state_reg)
                ST_RESULT: begin
                    if (wordDone && resLeft_reg == 2'd2) begin
                        resLeft_reg <= 2'd1;
                    end else if (opcodeSlot) begin
                        if (decIllegal) begin
                            resLo_reg <= `RESP_ILLEGAL;
                        end else if (decOpc == `OP_NULL) begin
                            resLo_reg <= `RESP_COMPLETE;
                        end else begin
                            opWord_reg <= rxWord[15:0];
                            tgt_reg <= decTgt;
                            needHalt_reg <= decHalt;
                            hasAddr_reg <= decAddr;
                            extLeft_reg <= decExt;
                            extIdx_reg <= 3'd0;
                            data_reg <= 32'h00000000;
                            rdChain_reg <= 1'b0;
                            wrChain_reg <= 1'b0;
                            state_reg <= (decExt == 3'd0) ? ST_EXEC : ST_EXT;
                        end
                    end
                end
                ST_EXT: begin
                    if (wordDone) begin
                        // operands arrive most significant word first
                        if (hasAddr_reg && extIdx_reg < 3'd2) begin
                            addr_reg <= {addr_reg[15:0], rxWord[15:0]};
                        end else begin
                            data_reg <= {data_reg[15:0], rxWord[15:0]};
                        end
                        extIdx_reg <= extIdx_reg + 3'd1;
                        extLeft_reg <= extLeft_reg - 3'd1;
                        if (extLeft_reg == 3'd1) begin
                            state_reg <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    if (!accReq_reg) begin
                        resLeft_reg <= 2'd1;
                        if (needHalt_reg && !coreHalted) begin
                            resLo_reg <= `RESP_BUS_ERR;
                            state_reg <= ST_RESULT;
                        end else if (tgt_reg == TGT_NONE) begin
                            resumeReq_reg <= 1'b1;
                            resLo_reg <= `RESP_COMPLETE;
                            state_reg <= ST_RESULT;
                        end else begin
                            accAddr_reg <= (tgt_reg == TGT_MEMORY) ? alignedAddr : addr_reg;
                            accReq_reg <= 1'b1;
                        end
                    end else if (accAck) begin
                        accReq_reg <= 1'b0;
                        state_reg <= ST_RESULT;
                        resLeft_reg <= 2'd1;
                        if (accErr) begin
                            resLo_reg <= `RESP_BUS_ERR;
                        end else if (accWrite) begin
                            resLo_reg <= `RESP_COMPLETE;
                        end else if (tgt_reg == TGT_MEMORY && curSize != SZ_LONG) begin
                            resLo_reg <= {1'b0, accRdata[15:0]};
                        end else begin
                            resHi_reg <= {1'b0, accRdata[31:16]};
                            resLo_reg <= {1'b0, accRdata[15:0]};
                            resLeft_reg <= 2'd2;
                        end
                        if (tgt_reg == TGT_MEMORY) begin
                            addr_reg <= accAddr_reg + addrStep;
                            rdChain_reg <= !accWrite && !accErr;
                            wrChain_reg <= accWrite && !accErr;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_RESULT;
                end
            endcase
        end
    end

    assign accReq = accReq_reg;
    assign accTarget = tgt_reg;
    assign accWrite = !opWord_reg[`DIR_BIT];
    assign accSize = curSize;
    assign accAddr = accAddr_reg;
    assign accWdata = data_reg;
    assign accRegClass = opWord_reg[`AD_BIT];
    assign accRegNum = opWord_reg[`REGN_MSB:`REGN_LSB];
    assign resumeReq = resumeReq_reg;

    // bookkeeping seen by software
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lastResp_reg <= `RESP_COMPLETE;
            cmdCount_reg <= 16'h0000;
        end else if (wordDone) begin
            lastResp_reg <= txWord;
            if (opcodeSlot) begin
                cmdCount_reg <= cmdCount_reg + 16'h0001;
            end
        end
    end

    // bus slave: one wait cycle on every access, unmapped reads return zero
    assign waitrequest = (read | write) & ~busAck_reg;
    assign readdata = readdata_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busAck_reg <= 1'b0;
            readdata_reg <= 32'h00000000;
        end else begin
            busAck_reg <= (read | write) & ~busAck_reg;
            if (read && !busAck_reg) begin
                case (address)
                    `REG_CTRL: readdata_reg <= {31'h00000000, linkEnable_reg};
                    `REG_STATUS: readdata_reg <= {20'h00000, wrChain_reg, rdChain_reg, state_reg,
                                                  opWord_reg[15:10], accReq_reg, coreHalted};
                    `REG_LAST_RESP: readdata_reg <= {15'h0000, lastResp_reg};
                    `REG_BLOCK_ADDR: readdata_reg <= addr_reg;
                    `REG_CMD_COUNT: readdata_reg <= {16'h0000, cmdCount_reg};
                    default: readdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // turning the link off mid frame drops that frame; the host must resynchronise
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            linkEnable_reg <= `CTRL_RESET;
        end else if (write && busAck_reg && address == `REG_CTRL) begin
            linkEnable_reg <= writedata[0];
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_opcode_decode;
        opcodeSlot;
    endsequence

    sequence s_resume_start;
        state_reg == ST_EXEC && !accReq_reg && tgt_reg == TGT_NONE && needHalt_reg && coreHalted;
    endsequence

    property p_illegal_resp;
        s_opcode_decode ##0 decIllegal |=> state_reg == ST_RESULT && txWord == `RESP_ILLEGAL;
    endproperty
    a_illegal_resp: assert property (p_illegal_resp) else $error("illegal opcode not answered");

    property p_reserved_size;
        s_opcode_decode ##0 (decSized && decSize == SZ_RSVD) |=> !accReq_reg [*4];
    endproperty
    a_reserved_size: assert property (p_reserved_size) else $error("reserved size started access");

    property p_null_cmd;
        s_opcode_decode ##0 (decOpc == `OP_NULL) |=> txWord == `RESP_COMPLETE && !accReq_reg;
    endproperty
    a_null_cmd: assert property (p_null_cmd) else $error("null command misbehaved");

    property p_halt_err;
        state_reg == ST_EXEC && !accReq_reg && needHalt_reg && !coreHalted
            |=> !accReq_reg && !resumeReq && txWord == `RESP_BUS_ERR;
    endproperty
    a_halt_err: assert property (p_halt_err) else $error("halted-only command ran");

    property p_not_ready;
        state_reg != ST_RESULT |-> txWord == `RESP_NOT_READY;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("busy phase not answering not ready");

    property p_direction;
        accReq |-> accWrite == !opWord_reg[`DIR_BIT];
    endproperty
    a_direction: assert property (p_direction) else $error("direction mismatch");

    property p_reg_fields;
        accReq && accTarget == TGT_CORE_REG
            |-> accRegClass == opWord_reg[3] && accRegNum == opWord_reg[2:0];
    endproperty
    a_reg_fields: assert property (p_reg_fields) else $error("register select wrong");

    property p_mem_size;
        accReq && accTarget == TGT_MEMORY |-> accSize == opWord_reg[7:6] && accSize != SZ_RSVD
            && (accSize != SZ_LONG || accAddr[1:0] == 2'b00);
    endproperty
    a_mem_size: assert property (p_mem_size) else $error("memory size or alignment wrong");

    property p_access_hold;
        accReq && !accAck |=> accReq && $stable(accAddr) && $stable(accWdata);
    endproperty
    a_access_hold: assert property (p_access_hold) else $error("access dropped before ack");

    property p_resume;
        s_resume_start |=> resumeReq ##1 !resumeReq;
    endproperty
    a_resume: assert property (p_resume) else $error("resume pulse wrong");
endmodule
`default_nettype wire

// ==== core/debug_serial_shifter.sv ====
// serial shifter of the debug link: samples the link clock and moves 17-bit frames
`timescale 1ns/1ps
`default_nettype none
`include "debug_cmd_map.svh"

module debug_serial_shifter (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        enable,
    input  wire logic        serialClk,
    input  wire logic        serialIn,
    input  wire logic [16:0] txWord,
    output logic             serialOut,
    output logic             wordDone,
    output logic [16:0]      rxWord
);
    logic        clkS1_reg;
    logic        clkS2_reg;
    logic        clkS3_reg;
    logic        dinS1_reg;
    logic        dinS2_reg;
    logic [4:0]  cnt_reg;
    logic [15:0] rxShift_reg;
    logic [16:0] txShift_reg;
    logic        linkEdge;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clkS1_reg <= 1'b0;
            clkS2_reg <= 1'b0;
            clkS3_reg <= 1'b0;
            dinS1_reg <= 1'b0;
            dinS2_reg <= 1'b0;
        end else begin
            clkS1_reg <= serialClk;
            clkS2_reg <= clkS1_reg;
            clkS3_reg <= clkS2_reg;
            dinS1_reg <= serialIn;
            dinS2_reg <= dinS1_reg;
        end
    end

    assign linkEdge = clkS2_reg & ~clkS3_reg;
    // done and the word are combinational so the next reply is loaded before the next edge can come
    assign wordDone = enable & linkEdge & (cnt_reg == `FRAME_LAST_BIT);
    assign rxWord = {rxShift_reg, dinS2_reg};
    assign serialOut = txShift_reg[16];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 5'h00;
            rxShift_reg <= 16'h0000;
            txShift_reg <= `RESP_NOT_READY;
        end else if (!enable) begin
            cnt_reg <= 5'h00;
            txShift_reg <= txWord;
        end else if (linkEdge) begin
            rxShift_reg <= rxWord[15:0];
            txShift_reg <= {txShift_reg[15:0], 1'b0};
            cnt_reg <= (cnt_reg == `FRAME_LAST_BIT) ? 5'h00 : cnt_reg + 5'h01;
        end else if (cnt_reg == 5'h00) begin
            txShift_reg <= txWord;
        end
    end
endmodule
`default_nettype wire

// ==== test/debug_command_decoder_bench.sv ====
// bench of the debug command decoder: bus, link and access-port scenarios
`timescale 1ns/1ps
`default_nettype none
`include "debug_cmd_map.svh"

module debug_command_decoder_bench;
    import debug_cmd_pkg::*;
    logic core_clk, rstn, read, write, serClk, serIn, coreHalted, errNext;
    logic        accAck = 1'b0;
    logic        accErr = 1'b0;
    logic [15:0] refOps [4] = '{16'h0dc0, 16'hfc00, 16'h050b, 16'h1c00};
    logic [4:0]  address;
    logic [31:0] writedata, q, capAddr, capWdata;
    logic [31:0] accRdata = 32'h1234_5678;
    logic [5:0]  capOp;
    int          mismatches, checks_done, accCnt, resumeCnt;
    wire logic [31:0] readdata, accAddr, accWdata;
    wire logic [2:0]  accRegNum;
    wire logic waitrequest, serOut, accReq, accWrite, accRegClass, resumeReq;
    acc_target_t accTarget;
    op_size_t    accSize;

    debug_command_decoder dut (.core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .debugSerialClock(serClk), .debugSerialIn(serIn), .debugSerialOut(serOut),
        .coreHalted(coreHalted), .accReq(accReq), .accTarget(accTarget), .accWrite(accWrite),
        .accSize(accSize), .accAddr(accAddr), .accWdata(accWdata), .accRegClass(accRegClass),
        .accRegNum(accRegNum), .accAck(accAck), .accErr(accErr), .accRdata(accRdata),
        .resumeReq(resumeReq));
    debug_host_model host (.clk(core_clk), .serialClk(serClk), .serialIn(serIn), .serialOut(serOut));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // core side: acknowledges each access one cycle after it is seen
    always @(posedge core_clk) begin
        accAck <= accReq && !accAck;
        accErr <= accReq && !accAck && errNext;
        if (accReq && !accAck) begin
            accCnt   <= accCnt + 1;
            capOp    <= {accWrite, accSize, accTarget};
            capAddr  <= accAddr;
            capWdata <= accWdata;
        end
        if (resumeReq === 1'b1)
            resumeCnt <= resumeCnt + 1;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic lk(input logic [15:0] tx, input logic [16:0] exp);
        logic [16:0] r;
        host.xfer(tx, r);
        chk({15'h0, r}, {15'h0, exp});
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        if (n >= 20) begin
            mismatches++;
            end_sim();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask

    initial begin
        #2_000_000;
        mismatches++;
        end_sim();
    end

    initial begin
        {rstn, read, write, address, writedata, coreHalted, errNext} = '0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        bus(1'b0, `REG_CTRL, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, 5'h14, 32'hffff_ffff);
        bus(1'b0, 5'h14, 32'h0);
        chk(q, 32'h0);
        $display("register test done");
        lk(16'h0000, `RESP_COMPLETE);
        lk(16'h0d80, `RESP_COMPLETE);
        lk(16'h0000, `RESP_NOT_READY);
        lk(16'h0010, `RESP_NOT_READY);
        lk(16'h0000, 17'h01234);
        lk(16'h0000, 17'h05678);
        chk({26'h0, capOp}, {26'h0, 1'b0, SZ_LONG, TGT_MEMORY});
        chk(capAddr, 32'h10);
        lk(16'h1540, `RESP_COMPLETE);
        lk(16'h0000, 17'h05678);
        chk({26'h0, capOp}, {26'h0, 1'b0, SZ_WORD, TGT_MEMORY});
        chk(capAddr, 32'h14);
        errNext <= 1'b1;
        lk(16'h1000, `RESP_COMPLETE);
        lk(16'h0000, `RESP_NOT_READY);
        lk(16'h0021, `RESP_NOT_READY);
        lk(16'h00ab, `RESP_NOT_READY);
        lk(16'h0000, `RESP_BUS_ERR);
        chk({26'h0, capOp}, {26'h0, 1'b1, SZ_BYTE, TGT_MEMORY});
        chk(capAddr, 32'h21);
        chk(capWdata, 32'hab);
        errNext <= 1'b0;
        $display("memory test done");
        // reserved size, unknown opcode, then halted-only commands on a running core
        foreach (refOps[i]) begin
            q = accCnt + resumeCnt;
            lk(refOps[i], `RESP_COMPLETE);
            lk(16'h0000, i < 2 ? `RESP_ILLEGAL : `RESP_BUS_ERR);
            chk(accCnt + resumeCnt, q);
        end
        $display("refusal test done");
        coreHalted <= 1'b1;
        lk(16'h050b, `RESP_COMPLETE);
        lk(16'h0000, 17'h01234);
        lk(16'h0000, 17'h05678);
        chk({22'h0, capOp, accRegClass, accRegNum}, {22'h0, 1'b0, SZ_BYTE, TGT_CORE_REG, 1'b1, 3'h3});
        lk(16'h1c00, `RESP_COMPLETE);
        lk(16'h0000, `RESP_COMPLETE);
        chk(resumeCnt, 1);
        $display("halted test done");
        end_sim();
    end
endmodule

`default_nettype wire

// ==== test/debug_host_model.sv ====
// behavioural development system: master of the serial debug link
`timescale 1ns/1ps
`default_nettype none

module debug_host_model (
    input  wire logic clk,
    output logic      serialClk,
    output logic      serialIn,
    input  wire logic serialOut
);
    initial begin
        serialClk = 1'b0;
        serialIn  = 1'b0;
    end

    // link clock stands low between frames; 800 ns per bit, moved only right after a core clock edge
    task automatic xfer(input logic [15:0] tx, output logic [16:0] rx);
        logic [16:0] w;
        w = {1'b0, tx};
        for (int i = 16; i >= 0; i--) begin
            serialIn <= w[i];
            repeat (4) @(posedge clk);
            rx[i] = serialOut;
            serialClk <= 1'b1;
            repeat (4) @(posedge clk);
            serialClk <= 1'b0;
        end
        // released line must not keep showing the last bit
        serialIn <= ~w[0];
        repeat (12) @(posedge clk);
    endtask
endmodule

`default_nettype wire
